/* File: logic/sar_adc_offset_cal_sequencer.sv */
// Purpose: Frame sequencer with offset calibration for a 10-bit SAR converter
// Assumes: Host drives select and serial clock; analog core supplies codes
// Notes: Serial pins pass three flops; edges found on the 200 MHz clock
`timescale 1ns/1ps
module sar_adc_offset_cal_sequencer (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire cal_seq_pkg::analog_t i_analog,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  output logic o_cal_busy,
  output logic [cal_seq_pkg::RESULT_W-1:0] o_offset_store
);

  cal_seq_pkg::seq_reg_t r;
  cal_seq_pkg::seq_reg_t next_r;

  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic [cal_seq_pkg::RESULT_W-1:0] corrected;

  // ==========================================================
  // Edge detection on the second and third flops only
  assign cs_low = ~r.cs_sync[1];
  assign cs_fall = r.cs_sync[2] & ~r.cs_sync[1];
  assign cs_rise = ~r.cs_sync[2] & r.cs_sync[1];
  assign sclk_fall = r.sclk_sync[2] & ~r.sclk_sync[1];

  // Saturate at zero rather than wrap for small codes
  assign corrected = (i_analog.raw > r.offset) ?
    cal_seq_pkg::RESULT_W'(i_analog.raw - r.offset) : '0;

  // ==========================================================
  // Sequencer
  always_comb begin
    next_r = r;
    next_r.cs_sync = {r.cs_sync[1:0], i_cs_n};
    next_r.sclk_sync = {r.sclk_sync[1:0], i_sclk};
    if (cs_fall) begin
      next_r.edges = '0;
      next_r.sdo = 1'b0;
      next_r.sdo_oe_n = 1'b0;
      if (!r.powered_cal_done) begin
        next_r.state = cal_seq_pkg::ST_STARTUP_CAL;
        next_r.cal_busy = 1'b1;
        next_r.shifter = '0;
      end else begin
        next_r.state = cal_seq_pkg::ST_CONVERT;
        next_r.cal_busy = 1'b0;
        // Second zero sits on top; LSB must leave on edge 11, before edge 12 forces low
        next_r.shifter = {1'b0, corrected, 1'b0};
      end
    end else if (cs_rise || !cs_low) begin
      // Early end drops any run in progress; store untouched
      next_r.state = cal_seq_pkg::ST_IDLE;
      next_r.cal_busy = 1'b0;
      next_r.sdo = 1'b0;
      next_r.sdo_oe_n = 1'b1;
    end else if (sclk_fall) begin
      if (r.edges != cal_seq_pkg::EDGE_MAX) begin
        next_r.edges = r.edges + 6'h01;
      end
      case (r.state)
        cal_seq_pkg::ST_STARTUP_CAL: begin
          next_r.sdo = 1'b0;
          if (r.edges + 6'h01 == cal_seq_pkg::POWERUP_CAL_EDGES) begin
            next_r.offset = i_analog.measured;
            next_r.powered_cal_done = 1'b1;
            next_r.cal_busy = 1'b0;
            next_r.state = cal_seq_pkg::ST_TAIL;
          end
        end
        cal_seq_pkg::ST_CONVERT: begin
          // Shift out second zero then MSB first
          next_r.sdo = r.shifter[cal_seq_pkg::RESULT_W+1];
          next_r.shifter = {r.shifter[cal_seq_pkg::RESULT_W:0], 1'b0};
          if (r.edges + 6'h01 >= cal_seq_pkg::DATA_EDGES) begin
            next_r.sdo = 1'b0;
            next_r.state = cal_seq_pkg::ST_TAIL;
          end
        end
        cal_seq_pkg::ST_TAIL: begin
          next_r.sdo = 1'b0;
          if (r.edges + 6'h01 == cal_seq_pkg::RUN_CAL_START_EDGE) begin
            next_r.cal_busy = r.powered_cal_done;
          end
          if (r.cal_busy && r.edges + 6'h01 == cal_seq_pkg::RUN_CAL_END_EDGE) begin
            next_r.offset = i_analog.measured;
            next_r.cal_busy = 1'b0;
          end
        end
        default: begin
          next_r.state = cal_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      r.cs_sync <= 3'h7;
      r.sclk_sync <= 3'h7;
      r.state <= cal_seq_pkg::ST_IDLE;
      r.edges <= '0;
      r.powered_cal_done <= 1'b0;
      r.offset <= cal_seq_pkg::OFFSET_RESET;
      r.shifter <= '0;
      r.sdo <= 1'b0;
      r.sdo_oe_n <= 1'b1;
      r.cal_busy <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Offset exposed for observation only; no serial path reaches it
  assign o_offset_store = r.offset;
  assign o_sdo = r.sdo;
  assign o_sdo_oe_n = r.sdo_oe_n;
  assign o_cal_busy = r.cal_busy;

endmodule

/* File: logic/cal_seq_pkg.sv */
// Purpose: Constants and types for the SAR converter offset calibration sequencer
// Assumes: Serial clock and chip select are sampled by the 200 MHz system clock
// Notes: Functional notes follow
// Functional notes
// - First frame after power-up calibrates, no conversion
// - Power-up calibration needs 16 falling edges
// - Data output low while calibrating
// - Short first frame leaves store unchanged
// - Conversions corrected by stored offset value
// - Normal calibration needs 32 edges in frame
// - First 12 edges convert and shift result
// - Calibration runs edge 17 through edge 32
// - Output low after edge 12, released on deselect
// - Short normal frame keeps previous offset
// - Offset store clears to zero at power-up
// - Offset store is internal only
// - Leading zero, second zero, then result bits
// - Result is 10-bit unsigned straight binary
package cal_seq_pkg;

  // ==========================================================
  // Widths and edge counts
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned EDGE_W = 6;
  localparam logic [EDGE_W-1:0] POWERUP_CAL_EDGES = 6'h10;
  localparam logic [EDGE_W-1:0] DATA_EDGES = 6'h0c;
  localparam logic [EDGE_W-1:0] RUN_CAL_START_EDGE = 6'h11;
  localparam logic [EDGE_W-1:0] RUN_CAL_END_EDGE = 6'h20;
  localparam logic [EDGE_W-1:0] EDGE_MAX = 6'h3f;
  localparam logic [RESULT_W-1:0] OFFSET_RESET = 10'h000;

  // ==========================================================
  // Host-side timing, kept for reference only; neither the logic nor the bench uses it
  localparam int unsigned CLOCK_PERIOD_PS = 5000;
  localparam int unsigned MIN_ACQUIRE_INTERVAL_NS = 235;
  localparam int unsigned MIN_ACQUIRE_CYCLES =
    (MIN_ACQUIRE_INTERVAL_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int unsigned CAL_DURATION_SCLK_PERIODS = 15;
  localparam int unsigned CAL_CLOCK_RATE_LIMIT_HIGH_MHZ = 14;
  localparam int unsigned CAL_CLOCK_RATE_LIMIT_LOW_MHZ = 12;

  // ==========================================================
  // Sequencer state
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONVERT = 4'h2,
    ST_STARTUP_CAL = 4'h4,
    ST_TAIL = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic [RESULT_W-1:0] raw;
    logic [RESULT_W-1:0] measured;
  } analog_t;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    seq_state_t state;
    logic [EDGE_W-1:0] edges;
    logic powered_cal_done;
    logic [RESULT_W-1:0] offset;
    logic [RESULT_W+1:0] shifter;
    logic sdo;
    logic sdo_oe_n;
    logic cal_busy;
  } seq_reg_t;

endpackage

/* File: verif/cal_seq_sva.sv */
// Purpose: Port checks for the calibration sequencer
// Assumes: Measured offset steady during a frame
// Notes: Bound from the bench
`timescale 1ns/1ps
module cal_seq_sva (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire cal_seq_pkg::analog_t i_analog,
  input wire logic o_sdo,
  input wire logic o_sdo_oe_n,
  input wire logic o_cal_busy,
  input wire logic [cal_seq_pkg::RESULT_W-1:0] o_offset_store
);
  // =========
  // Checks
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  chk_busy_quiet: assert property (o_cal_busy |-> !o_sdo)
    else $error("sdo high in cal");
  chk_store_cause: assert property ($changed(o_offset_store) |-> $fell(o_cal_busy))
    else $error("store moved");
  chk_store_value: assert property ($changed(o_offset_store) |-> o_offset_store == i_analog.measured)
    else $error("store value");
  chk_busy_frame: assert property ($rose(o_cal_busy) |-> !i_cs_n)
    else $error("busy outside frame");
  chk_busy_bound: assert property ($rose(o_cal_busy) |-> ##[1:400] !o_cal_busy)
    else $error("cal stuck");
  chk_idle_free: assert property (i_cs_n [*6] |-> !o_cal_busy && o_sdo_oe_n)
    else $error("idle busy");
  chk_lead_zero: assert property ($fell(o_sdo_oe_n) |-> !o_sdo)
    else $error("lead bit");
  chk_release_out: assert property ($rose(i_cs_n) |-> ##[1:5] o_sdo_oe_n)
    else $error("no release");
  cover property ($fell(o_cal_busy) && $changed(o_offset_store));
  cover property ($rose(i_cs_n) ##1 o_cal_busy);
  cover property ($fell(o_sdo_oe_n) && !o_cal_busy);
endmodule

/* File: verif/host_model.sv */
// Purpose: Host driving select and serial clock
// Assumes: Moves on the falling system clock
// Notes: Serial clock idles high outside frames
`timescale 1ns/1ps
module host_model (
  input wire logic i_clock,
  input wire logic i_sdo,
  output logic o_cs_n,
  output logic o_sclk,
  output logic [31:0] o_cap
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_cap = 32'h0;
  end
  // Bit taken just before each fall, once settled
  task automatic frame(input int n);
    o_cs_n = 1'b0;
    repeat (6) @(negedge i_clock);
    for (int k = 0; k < n; k++) begin
      o_cap = {o_cap[30:0], i_sdo};
      o_sclk = 1'b0;
      repeat (8) @(negedge i_clock);
      o_sclk = 1'b1;
      repeat (8) @(negedge i_clock);
    end
    o_cs_n = 1'b1;
    repeat (60) @(negedge i_clock);
  endtask
endmodule

/* File: verif/sar_adc_offset_cal_sequencer_test.sv */
// Purpose: Bench for the calibration sequencer
// Assumes: Store port read for observation only
// Notes: Frames come from the host model
`timescale 1ns/1ps
module sar_adc_offset_cal_sequencer_test;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic cs_n, sclk, sdo, oe_n, busy;
  logic [31:0] cap;
  logic [9:0] store;
  cal_seq_pkg::analog_t analog = '0;
  int fail_count = 0;
  int n_tests = 0;
  always #2.5 i_clock = ~i_clock;
  sar_adc_offset_cal_sequencer u_sar_adc_offset_cal_sequencer (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_analog(analog), .o_sdo(sdo),
    .o_sdo_oe_n(oe_n), .o_cal_busy(busy), .o_offset_store(store));
  host_model u_host_model (.i_clock(i_clock), .i_sdo(sdo), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_cap(cap));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic run(input int n, input logic [9:0] raw, input logic [9:0] meas);
    analog = {raw, meas};
    u_host_model.frame(n);
  endtask
  // =========
  // Scenarios
  task automatic t_short_first();
    run(15, 10'h3ff, 10'h155);
    check(store, 32'h0);
    check(cap[14:0], 32'h0);
  endtask
  task automatic t_powerup();
    run(16, 10'h3ff, 10'h005);
    check(store, 32'h5);
    check(cap[15:0], 32'h0);
  endtask
  task automatic t_normal_cal();
    run(32, 10'h2a5, 10'h00a);
    check(cap, {2'b00, 10'h2a0, 20'h0});
    check(store, 32'ha);
    check(oe_n, 32'h1);
  endtask
  task automatic t_short_normal();
    run(31, 10'h3ff, 10'h1ff);
    check(cap[30:19], {2'b00, 10'h3f5});
    check(store, 32'ha);
  endtask
  task automatic t_saturate();
    run(12, 10'h003, 10'h000);
    check(cap[11:0], 32'h0);
  endtask
  initial begin
    repeat (3) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    t_short_first();
    t_powerup();
    t_normal_cal();
    t_short_normal();
    t_saturate();
    conclude();
  end
  initial begin
    #20us;
    fail_count++;
    conclude();
  end
endmodule
bind sar_adc_offset_cal_sequencer cal_seq_sva u_cal_seq_sva (.i_clock(i_clock),
  .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_analog(i_analog), .o_sdo(o_sdo),
  .o_sdo_oe_n(o_sdo_oe_n), .o_cal_busy(o_cal_busy), .o_offset_store(o_offset_store));
